// ### common/cco_pkg.sv
// Package for the counter compare output channel: times, cycle counts, modes and carriers.
// Assumes a single 200 MHz clock; every count here derives from that period.
// Behaviour
// - Output mode none: output is a plain output, compare flag stays cleared.
// - Comparator mode: output and flag set while count >= or <= comparison value.
// - Pulse mode: output asserted for the pulse duration when count reaches comparison.
// - With a main direction set, pulse triggers only when reached in that direction.
// - Pulse duration timing starts when the output is asserted.
// - Reaching the comparison value again during a pulse neither retriggers nor extends.
// - A duration changed mid-pulse applies from the next pulse only.
// - Duration zero: output held while the comparison holds, released when it fails.
// - Pulse duration spans 0 to 510 ms in 2 ms steps, default zero.
// - Gate-open interrupt on hardware gate rising edge while software gate is open.
// - Gate-close interrupt on hardware gate falling edge while software gate is open.
// - Comparator interrupt whenever the comparator triggers in the selected mode.
// - Overflow and underflow interrupts on passing upper or lower count limit.
// - Count and gate inputs have selectable max frequency 1 to 60 kHz, default 60.
// - Latch input has its own frequency selection, default 10 kHz, 40 us.
// - Running count is compared against the configured comparison value.
// - Hysteresis 0 to 255 counts damps toggling; zero and one disable it.

package cco_pkg;

  localparam int unsigned CLK_PERIOD_NS = 5;

  // Shortest accepted pulse per frequency choice and the 2 ms pulse unit, in nanoseconds.
  localparam int unsigned T_1K_NS  = 400000;
  localparam int unsigned T_2K_NS  = 200000;
  localparam int unsigned T_5K_NS  = 80000;
  localparam int unsigned T_10K_NS = 40000;
  localparam int unsigned T_30K_NS = 13000;
  localparam int unsigned T_60K_NS = 6700;
  localparam int unsigned T_UNIT_NS = 2000000;

  // Least times round up to whole cycles.
  localparam int unsigned CYC_1K  = (T_1K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_2K  = (T_2K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_5K  = (T_5K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_10K = (T_10K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_30K = (T_30K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_60K = (T_60K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_UNIT_CYC = T_UNIT_NS / CLK_PERIOD_NS;

  localparam int unsigned FLT_W  = 17;
  localparam int unsigned DIV_W  = 19;
  localparam int unsigned N_FLT  = 4;

  // Frequency selection codes.
  localparam logic [2:0] FREQ_1K  = 3'h0;
  localparam logic [2:0] FREQ_2K  = 3'h1;
  localparam logic [2:0] FREQ_5K  = 3'h2;
  localparam logic [2:0] FREQ_10K = 3'h3;
  localparam logic [2:0] FREQ_30K = 3'h4;
  localparam logic [2:0] FREQ_60K = 3'h5;

  // Filter lane positions.
  localparam int unsigned LANE_A     = 0;
  localparam int unsigned LANE_B     = 1;
  localparam int unsigned LANE_GATE  = 2;
  localparam int unsigned LANE_LATCH = 3;

  localparam logic [7:0]  PULSE_DUR_RST = 8'h00;
  localparam logic [7:0]  HYST_RST      = 8'h00;
  localparam logic [31:0] CMP_RST       = 32'h0000_0000;

  typedef enum logic [1:0] {CCO_OUT_NONE, CCO_OUT_GE, CCO_OUT_LE, CCO_OUT_PULSE} cco_out_mode_t;
  typedef enum logic [1:0] {CCO_DIR_NONE, CCO_DIR_UP, CCO_DIR_DOWN} cco_main_dir_t;

  // Channel configuration as supplied by the controller.
  typedef struct packed {
    cco_out_mode_t      out_mode;
    cco_main_dir_t      main_dir;
    logic signed [31:0] cmp_value;
    logic [7:0]         hyst;
    logic [7:0]         pulse_dur;
    logic               irq_gate_open;
    logic               irq_gate_close;
    logic               irq_cmp;
    logic               irq_ovf;
    logic               irq_unf;
    logic [2:0]         freq_cnt;
    logic [2:0]         freq_latch;
  } cco_cfg_t;

  // Count state reported by the counter core.
  typedef struct packed {
    logic signed [31:0] value;
    logic               step;
    logic               up;
    logic               ovf;
    logic               unf;
  } cco_cnt_t;

  // Interrupt causes raised together with the interrupt pulse.
  typedef struct packed {
    logic gate_open;
    logic gate_close;
    logic cmp;
    logic ovf;
    logic unf;
  } cco_irq_t;

endpackage

// ### hdl/cco_filter.sv
// Minimum pulse width filter for one input lane.
// Assumes the raw input is already synchronous to ref_clk.
`timescale 1ns/1ps

module cco_filter (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_b,
  input  wire logic                         raw,
  input  wire logic [cco_pkg::FLT_W-1:0]    min_cyc,
  output logic                              filt
);

  logic [cco_pkg::FLT_W-1:0] run;

  wire differs = raw != filt;
  wire reached = run >= min_cyc - cco_pkg::FLT_W'(1);

  // A new level passes only after it has stood min_cyc cycles; shorter pulses vanish.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      run  <= '0;
      filt <= 1'b0;
    end else if (!differs) begin
      run <= '0;
    end else if (reached) begin
      filt <= raw;
      run  <= '0;
    end else begin
      run <= run + cco_pkg::FLT_W'(1);
    end
  end

  short_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (filt != $past(filt)) |-> ($past(run) + cco_pkg::FLT_W'(1) >= $past(min_cyc)))
    else $error("Filter output changed before the minimum width elapsed.");

endmodule

// ### hdl/cco_top.sv
// Compare output, interrupt events and input filters of one counter channel.
// Assumes the counter core supplies its value, step and limit events on ref_clk.
`timescale 1ns/1ps

module cco_top #(
  parameter int unsigned FLT_CYC_1K     = cco_pkg::CYC_1K,
  parameter int unsigned FLT_CYC_2K     = cco_pkg::CYC_2K,
  parameter int unsigned FLT_CYC_5K     = cco_pkg::CYC_5K,
  parameter int unsigned FLT_CYC_10K    = cco_pkg::CYC_10K,
  parameter int unsigned PULSE_UNIT_CYC = cco_pkg::PULSE_UNIT_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire cco_pkg::cco_cfg_t cfg,
  input  wire cco_pkg::cco_cnt_t cnt,
  input  wire logic              software_gate_bit,
  input  wire logic              normal_out,
  input  wire logic              track_a_raw,
  input  wire logic              track_b_raw,
  input  wire logic              hardware_gate_input,
  input  wire logic              latch_raw,
  output logic                   track_a,
  output logic                   track_b,
  output logic                   gate_filt,
  output logic                   latch_filt,
  output logic                   channel_out,
  output logic                   compare_hit_flag,
  output logic                   hw_irq,
  output cco_pkg::cco_irq_t      irq_cause
);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Maps a frequency code to its minimum pulse width; unknown codes take the fastest.
  function automatic logic [cco_pkg::FLT_W-1:0] sel_cyc(input logic [2:0] code);
    unique case (code)
      cco_pkg::FREQ_1K:  sel_cyc = cco_pkg::FLT_W'(FLT_CYC_1K);
      cco_pkg::FREQ_2K:  sel_cyc = cco_pkg::FLT_W'(FLT_CYC_2K);
      cco_pkg::FREQ_5K:  sel_cyc = cco_pkg::FLT_W'(FLT_CYC_5K);
      cco_pkg::FREQ_10K: sel_cyc = cco_pkg::FLT_W'(FLT_CYC_10K);
      cco_pkg::FREQ_30K: sel_cyc = cco_pkg::FLT_W'(cco_pkg::CYC_30K);
      default:           sel_cyc = cco_pkg::FLT_W'(cco_pkg::CYC_60K);
    endcase
  endfunction

  // Input filters: count and gate lanes share one setting, latch has its own.
  wire [cco_pkg::FLT_W-1:0] cnt_min   = sel_cyc(cfg.freq_cnt);
  wire [cco_pkg::FLT_W-1:0] latch_min = sel_cyc(cfg.freq_latch);
  wire [cco_pkg::N_FLT-1:0] raw_in = {latch_raw, hardware_gate_input, track_b_raw, track_a_raw};
  wire [cco_pkg::N_FLT-1:0] flt_out;

  for (genvar i = 0; i < cco_pkg::N_FLT; i++) begin : g_flt
    cco_filter u_flt (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .raw     (raw_in[i]),
      .min_cyc ((i == cco_pkg::LANE_LATCH) ? latch_min : cnt_min),
      .filt    (flt_out[i])
    );
  end

  assign track_a    = flt_out[cco_pkg::LANE_A];
  assign track_b    = flt_out[cco_pkg::LANE_B];
  assign gate_filt  = flt_out[cco_pkg::LANE_GATE];
  assign latch_filt = flt_out[cco_pkg::LANE_LATCH];

  // Comparator state and pulse timer.
  logic                         cmp_on;
  logic                         pulse_on;
  logic                         zero_hold;
  logic [7:0]                   units_left;
  logic [cco_pkg::DIV_W-1:0]    div;
  logic                         gate_d;

  // Hysteresis of zero or one means none at all.
  wire signed [33:0] hyst_eff = (cfg.hyst > 8'h01) ? 34'(cfg.hyst) : 34'sh0;
  wire signed [33:0] val_w    = 34'(cnt.value);
  wire signed [33:0] cmp_w    = 34'(cfg.cmp_value);

  wire is_ge    = cfg.out_mode == cco_pkg::CCO_OUT_GE;
  wire is_le    = cfg.out_mode == cco_pkg::CCO_OUT_LE;
  wire is_pulse = cfg.out_mode == cco_pkg::CCO_OUT_PULSE;
  wire is_none  = cfg.out_mode == cco_pkg::CCO_OUT_NONE;

  // Level comparator with release held off by the hysteresis band.
  wire ge_set = val_w >= cmp_w;
  wire ge_clr = val_w < cmp_w - hyst_eff;
  wire le_set = val_w <= cmp_w;
  wire le_clr = val_w > cmp_w + hyst_eff;
  wire next_cmp_on = is_ge ? (cmp_on ? !ge_clr : ge_set) :
                     is_le ? (cmp_on ? !le_clr : le_set) : 1'b0;

  // A reach is a count step landing on the comparison value from an allowed direction.
  wire on_value = cnt.value == cfg.cmp_value;
  wire dir_ok   = (cfg.main_dir == cco_pkg::CCO_DIR_NONE) ||
                  ((cfg.main_dir == cco_pkg::CCO_DIR_UP) && cnt.up) ||
                  ((cfg.main_dir == cco_pkg::CCO_DIR_DOWN) && !cnt.up);
  wire reach_evt = is_pulse && cnt.step && on_value && dir_ok;

  wire dur_zero    = cfg.pulse_dur == cco_pkg::PULSE_DUR_RST;
  wire pulse_start = reach_evt && !pulse_on && !dur_zero;
  wire unit_last   = div == cco_pkg::DIV_W'(PULSE_UNIT_CYC - 1);
  wire pulse_end   = pulse_on && unit_last && (units_left == 8'h01);
  wire next_pulse_on = pulse_start || (pulse_on && !pulse_end && is_pulse);

  // Zero duration follows the condition from the qualified reach until it fails.
  wire next_zero = is_pulse && on_value && (zero_hold || (reach_evt && dur_zero));

  wire next_level = is_none ? 1'b0 : (next_cmp_on || next_pulse_on || next_zero);
  wire level_now  = cmp_on || pulse_on || zero_hold;
  wire next_out   = is_none ? normal_out : next_level;

  // Event decode for the interrupt pulse.
  wire gate_rise = gate_filt && !gate_d;
  wire gate_fall = !gate_filt && gate_d;
  cco_pkg::cco_irq_t next_cause;
  assign next_cause.gate_open  = cfg.irq_gate_open && gate_rise && software_gate_bit;
  assign next_cause.gate_close = cfg.irq_gate_close && gate_fall && software_gate_bit;
  assign next_cause.cmp        = cfg.irq_cmp && next_level && !level_now;
  assign next_cause.ovf        = cfg.irq_ovf && cnt.ovf;
  assign next_cause.unf        = cfg.irq_unf && cnt.unf;

  // Comparator and hold state.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_on    <= 1'b0;
      zero_hold <= 1'b0;
      gate_d    <= 1'b0;
    end else begin
      cmp_on    <= next_cmp_on;
      zero_hold <= next_zero;
      gate_d    <= gate_filt;
    end
  end

  // Pulse timer: the 2 ms divider restarts with the output so no partial unit is lost.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_on   <= 1'b0;
      units_left <= cco_pkg::PULSE_DUR_RST;
      div        <= '0;
    end else begin
      pulse_on <= next_pulse_on;
      if (pulse_start) begin
        units_left <= cfg.pulse_dur;
        div        <= '0;
      end else if (pulse_on) begin
        div <= unit_last ? '0 : div + cco_pkg::DIV_W'(1);
        if (unit_last) begin
          units_left <= units_left - 8'h01;
        end
      end
    end
  end

  // Registered outputs.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      channel_out      <= 1'b0;
      compare_hit_flag <= 1'b0;
      hw_irq           <= 1'b0;
      irq_cause        <= '0;
    end else begin
      channel_out      <= next_out;
      compare_hit_flag <= next_level;
      hw_irq           <= |next_cause;
      irq_cause        <= next_cause;
    end
  end

  none_flag_a: assert property (is_none |=> !compare_hit_flag)
    else $error("Compare flag set while output mode is none.");

  ge_level_a: assert property ((is_ge && ge_set) |=> (channel_out && compare_hit_flag))
    else $error("Comparator output not set at or above the comparison value.");

  le_release_a: assert property ((is_le && cmp_on && le_clr) |=> !compare_hit_flag)
    else $error("Comparator did not release beyond the hysteresis band.");

  pulse_len_a: assert property (pulse_start |=> (channel_out && (units_left == $past(cfg.pulse_dur)) && (div == '0)))
    else $error("Pulse did not start with the latched duration and a fresh divider.");

  wrong_dir_a: assert property ((is_pulse && cnt.step && !dir_ok && !pulse_on && !zero_hold
    && !is_ge && !is_le) |=> !channel_out)
    else $error("Pulse triggered against the main counting direction.");

  no_retrig_a: assert property ((pulse_on && reach_evt && !unit_last) |=> $stable(units_left))
    else $error("Running pulse was retriggered.");

  zero_release_a: assert property ((is_pulse && dur_zero && !pulse_on && !on_value) |=> !channel_out)
    else $error("Zero-duration output held after the condition failed.");

  div_range_a: assert property (div <= cco_pkg::DIV_W'(PULSE_UNIT_CYC - 1))
    else $error("Pulse divider passed one 2 ms unit.");

  gate_irq_a: assert property ((gate_rise && cfg.irq_gate_open && software_gate_bit) |=>
    (hw_irq && irq_cause.gate_open))
    else $error("Gate opening interrupt missing.");

  gate_close_a: assert property ((gate_fall && !software_gate_bit) |=> !irq_cause.gate_close)
    else $error("Gate closing interrupt raised with the software gate closed.");

  limit_irq_a: assert property ((cnt.ovf && cfg.irq_ovf) |=> (hw_irq && irq_cause.ovf))
    else $error("Overflow interrupt missing.");

endmodule

// ### verification/cco_src_model.sv
// Behavioural counter core that feeds the compare channel its count value and limit events.
// Assumes the bench calls its tasks at the falling edge of ref_clk, one call per cycle.
`timescale 1ns/1ps

module cco_src_model (
  input  wire logic        ref_clk,
  output cco_pkg::cco_cnt_t cnt
);
  // In move the value changes together with its step, as a real core reports an updated count.
  initial begin
    cnt = '0;
  end

  // Presents a value with no step, so the channel only sees a level change.
  task automatic load(input logic signed [31:0] v);
    cnt = '{value: v, step: 1'b0, up: 1'b0, ovf: 1'b0, unf: 1'b0};
    @(negedge ref_clk);
  endtask

  // One count pulse; passing a count limit wraps the value and marks it for one cycle.
  task automatic move(input logic dir_up);
    logic signed [31:0] v;
    v = dir_up ? cnt.value + 32'sh1 : cnt.value - 32'sh1;
    cnt = '{value: v, step: 1'b1, up: dir_up,
            ovf: dir_up && (cnt.value == 32'sh7fff_ffff),
            unf: !dir_up && (cnt.value == 32'sh8000_0000)};
    @(negedge ref_clk);
  endtask
endmodule

// ### verification/testbench.sv
// Self-checking bench for the counter compare channel: compare, pulse, events and filters.
// Assumes the design files and the counter core model are compiled before this file.
`timescale 1ns/1ps

module testbench;
  localparam int unsigned UNIT = 20;
  logic              ref_clk, rst_b, software_gate_bit, normal_out, hw_irq;
  logic              track_a_raw, track_b_raw, hardware_gate_input, latch_raw;
  logic              track_a, track_b, gate_filt, latch_filt, channel_out, compare_hit_flag;
  cco_pkg::cco_cfg_t cfg;
  cco_pkg::cco_cnt_t cnt;
  cco_pkg::cco_irq_t irq_cause;
  int                fails, n_checks, hi_cnt, n;

  // Short filter and pulse units keep the run brief; expectations scale from them.
  cco_top #(.FLT_CYC_1K(40), .FLT_CYC_2K(20), .FLT_CYC_5K(10), .FLT_CYC_10K(8),
            .PULSE_UNIT_CYC(UNIT)) cco_top_inst (.ref_clk, .rst_b, .cfg, .cnt,
    .software_gate_bit, .normal_out, .track_a_raw, .track_b_raw, .hardware_gate_input,
    .latch_raw, .track_a, .track_b, .gate_filt, .latch_filt, .channel_out,
    .compare_hit_flag, .hw_irq, .irq_cause);
  cco_src_model cco_src_model_inst (.ref_clk, .cnt);

  // Clock at 200 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Counts high cycles; the value read is the one before this edge's updates land.
  always @(posedge ref_clk) begin
    if (channel_out === 1'b1) begin
      hi_cnt <= hi_cnt + 1;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Waits a bounded time for the event pulse, then compares its cause set.
  task automatic wait_irq(input logic [4:0] cause, output int cyc);
    cyc = 0;
    while (hw_irq !== 1'b1 && cyc < 200) begin
      @(negedge ref_clk);
      cyc++;
    end
    if (cyc == 200) begin
      fails++;
      conclude();
    end
    chk(irq_cause, cause);
  endtask

  // No event may be raised during these cycles.
  task automatic quiet(input int cyc);
    repeat (cyc) begin
      @(negedge ref_clk);
      chk(hw_irq, 0);
    end
  endtask

  // A pulse must end within 300 cycles, three times its longest duration here.
  task automatic wait_low;
    int i;
    i = 0;
    while (channel_out !== 1'b0 && i < 300) begin
      @(negedge ref_clk);
      i++;
    end
    if (i == 300) begin
      fails++;
      conclude();
    end
  endtask

  // A hang anywhere ends the run through the same report.
  initial begin
    #400_000;
    fails++;
    conclude();
  end

  // Main sequence; every input changes at the falling edge.
  initial begin
    {fails, n_checks, hi_cnt} = '0;
    {rst_b, software_gate_bit, normal_out, track_a_raw, track_b_raw} = '0;
    {hardware_gate_input, latch_raw} = '0;
    cfg = '0;
    cfg.cmp_value = 32'sd100;
    cfg.freq_cnt = cco_pkg::FREQ_60K;
    cfg.freq_latch = cco_pkg::FREQ_10K;
    repeat (16) @(negedge ref_clk);
    chk({channel_out, compare_hit_flag, hw_irq}, 3'h0);
    rst_b = 1'b1;
    normal_out = 1'b1;
    cco_src_model_inst.load(32'sd100);
    @(negedge ref_clk);
    chk({channel_out, compare_hit_flag}, 2'h2);
    normal_out = 1'b0;
    cco_src_model_inst.load(32'sd100);
    chk({channel_out, compare_hit_flag}, 2'h0);
    cfg.irq_cmp = 1'b1;
    cfg.out_mode = cco_pkg::CCO_OUT_GE;
    cco_src_model_inst.load(32'sd99);
    chk({channel_out, compare_hit_flag, hw_irq}, 3'h0);
    cco_src_model_inst.load(32'sd100);
    chk({channel_out, compare_hit_flag, hw_irq, irq_cause}, 8'he4);
    cfg.hyst = 8'h04;
    cco_src_model_inst.load(32'sd96);
    chk(channel_out, 1);
    cco_src_model_inst.load(32'sd95);
    chk(channel_out, 0);
    cfg.hyst = 8'h01;
    cco_src_model_inst.load(32'sd100);
    cco_src_model_inst.load(32'sd99);
    chk(channel_out, 0);
    cfg.hyst = 8'h00;
    cfg.out_mode = cco_pkg::CCO_OUT_LE;
    cco_src_model_inst.load(32'sd101);
    chk(channel_out, 0);
    cco_src_model_inst.load(32'sd100);
    chk({channel_out, compare_hit_flag, hw_irq}, 3'h7);
    cfg.out_mode = cco_pkg::CCO_OUT_PULSE;
    cfg.pulse_dur = 8'h02;
    cco_src_model_inst.load(32'sd99);
    hi_cnt = 0;
    cco_src_model_inst.move(1'b1);
    chk({channel_out, hw_irq, irq_cause}, 7'h64);
    cfg.pulse_dur = 8'h05;
    cco_src_model_inst.move(1'b0);
    cco_src_model_inst.move(1'b1);
    cco_src_model_inst.load(32'sd100);
    wait_low();
    chk(hi_cnt, 2 * UNIT);
    hi_cnt = 0;
    cco_src_model_inst.move(1'b0);
    cco_src_model_inst.move(1'b1);
    cco_src_model_inst.load(32'sd100);
    wait_low();
    chk(hi_cnt, 5 * UNIT);
    cfg.main_dir = cco_pkg::CCO_DIR_UP;
    cfg.pulse_dur = 8'h01;
    cco_src_model_inst.load(32'sd101);
    cco_src_model_inst.move(1'b0);
    chk(channel_out, 0);
    cco_src_model_inst.move(1'b0);
    cco_src_model_inst.move(1'b1);
    chk(channel_out, 1);
    cco_src_model_inst.load(32'sd100);
    wait_low();
    cfg.main_dir = cco_pkg::CCO_DIR_NONE;
    cfg.pulse_dur = 8'h00;
    cco_src_model_inst.move(1'b0);
    cco_src_model_inst.move(1'b1);
    repeat (60) cco_src_model_inst.load(32'sd100);
    chk(channel_out, 1);
    cco_src_model_inst.load(32'sd101);
    chk(channel_out, 0);
    cfg.out_mode = cco_pkg::CCO_OUT_NONE;
    {cfg.irq_cmp, cfg.irq_ovf, cfg.irq_unf} = 3'h3;
    cco_src_model_inst.load(32'sh7fff_ffff);
    cco_src_model_inst.move(1'b1);
    chk({hw_irq, irq_cause}, 6'h22);
    cco_src_model_inst.move(1'b0);
    chk({hw_irq, irq_cause}, 6'h21);
    cco_src_model_inst.load(32'sd0);
    cfg.freq_cnt = cco_pkg::FREQ_1K;
    {cfg.irq_gate_open, cfg.irq_gate_close, software_gate_bit} = 3'h7;
    {track_a_raw, track_b_raw, hardware_gate_input} = 3'h7;
    wait_irq(5'h10, n);
    chk(n >= 40 && n <= 43, 1);
    chk({track_a, track_b, gate_filt}, 3'h7);
    hardware_gate_input = 1'b0;
    quiet(20);
    hardware_gate_input = 1'b1;
    quiet(60);
    hardware_gate_input = 1'b0;
    wait_irq(5'h08, n);
    software_gate_bit = 1'b0;
    hardware_gate_input = 1'b1;
    quiet(60);
    chk(gate_filt, 1);
    hardware_gate_input = 1'b0;
    quiet(60);
    latch_raw = 1'b1;
    repeat (4) @(negedge ref_clk);
    latch_raw = 1'b0;
    repeat (12) begin
      @(negedge ref_clk);
      chk(latch_filt, 0);
    end
    latch_raw = 1'b1;
    repeat (12) @(negedge ref_clk);
    chk(latch_filt, 1);
    // A negative comparison value exercises the signed compare and most value bits.
    cfg.cmp_value = -32'sd5;
    cfg.out_mode = cco_pkg::CCO_OUT_GE;
    cco_src_model_inst.load(-32'sd6);
    chk(channel_out, 0);
    cco_src_model_inst.load(-32'sd5);
    chk({channel_out, compare_hit_flag}, 2'h3);
    // Downward main direction: only a reach while counting down may fire.
    cfg.out_mode = cco_pkg::CCO_OUT_PULSE;
    cfg.main_dir = cco_pkg::CCO_DIR_DOWN;
    cfg.pulse_dur = 8'h01;
    cco_src_model_inst.load(-32'sd4);
    cco_src_model_inst.move(1'b0);
    chk(channel_out, 1);
    wait_low();
    cco_src_model_inst.load(-32'sd6);
    cco_src_model_inst.move(1'b1);
    chk(channel_out, 0);
    // A slower latch setting must hold off a release the faster one would pass.
    cfg.freq_latch = cco_pkg::FREQ_2K;
    latch_raw = 1'b0;
    repeat (12) @(negedge ref_clk);
    chk(latch_filt, 1);
    repeat (10) @(negedge ref_clk);
    chk(latch_filt, 0);
    conclude();
  end
endmodule
